// File: core/sds_store.sv
// Descriptor store: device, configuration and unit descriptors over APB
// Notes on behaviour
// [R01] Boot enable: 00h off, 01h on
// [R02] Descriptor access gated after partial boot init
// [R03] Reset power mode from initial power field
// [R04] Priority unit; 7Fh means all equal
// [R05] Removal method codes 00h-03h, rest reserved
// [R06] Background stop within latency times 10 ms
// [R07] Spec version 0210h in BCD
// [R08] Read-only maker code at offset 18h
// [R09] Outstanding transfer request limit reports 02h
// [R10] Clock update split: origin, unit, period
// [R11] Time unit zero makes period undefined
// [R12] Host picks origin by clock ownership
// [R13] Feature bitmap reports 7Fh, bit 7 reserved
// [R14] Firmware update timeout reports 0Ah seconds
// [R15] One shared queue of depth 20h
// [R16] Presolder state timeout field reports 12h
// [R17] Continuation 00h applies, 01h defers
// [R18] Unit count computed; four well-known units
// [R19] Unit enable: 00h enabled, 01h disabled
// [R20] Boot id: 00h none, 01h A, 02h B
// [R21] Protect code tied to its enable flag
// [R22] Block size exponent at least 0Ch
// [R23] Query request 16h answered by 36h
// [R24] Length at 00h, type at 01h
// [R25] Reserved reads zero; read-only writes ignored
// [R26] Applied configuration visible in descriptors
//
// The APB register port was chosen for this implementation.
`include "sds_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sds_store
  import sds_pkg::*;
#(
  // Arbitrary value, not a real maker code
  parameter logic [15:0] MAKER_CODE = 16'h5a5a,
  parameter logic [15:0] BUILD_DATE = 16'h0000,
  parameter logic [15:0] DEVICE_REV = 16'h0000,
  parameter logic [31:0] PSA_MAX_DATA = 32'h0000_0000,
  parameter int unsigned BG_STOP_CYCLES =
    5 * `SDS_BG_UNIT_MS * `SDS_CYC_PER_MS
)(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic boot_partial_phase,
  input wire logic init_done,
  input wire logic power_on_protect_flag,
  input wire logic permanent_protect_flag,
  input wire logic bg_stop_req,
  input wire logic bg_idle,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output sds_status_t status
);

  typedef struct packed {
    sds_qstate_t qstate;
    logic [7:0] req_code;
    logic [7:0] resp_code;
    logic [7:0] cont_flag;
    sds_devcfg_t live;
    sds_devcfg_t staged;
    sds_unit_t [`SDS_UNITS-1:0] units;
    sds_unit_t [`SDS_UNITS-1:0] staged_units;
    logic bg_busy;
    logic [31:0] bg_cnt;
    sds_status_t status;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sds_state_t;

  sds_state_t s_q;
  sds_state_t s_d;

  function automatic logic [7:0] pick(input logic ok, input logic [7:0] nv,
                                      input logic [7:0] ov);
    pick = ok ? nv : ov;
  endfunction

  function automatic logic [31:0] dev_word(input logic [5:0] idx,
                                           input sds_devcfg_t c,
                                           input logic [7:0] nlu);
    dev_word = 32'h0000_0000; // R25
    case (idx)
      `SDS_OFS_LENGTH: dev_word[7:0] = `SDS_DEV_LEN_VAL; // R24
      `SDS_OFS_TYPE: dev_word[7:0] = `SDS_DEV_ID_VAL; // R24
      `SDS_OFS_PROTOCOL: dev_word[7:0] = 8'h00;
      `SDS_OFS_UNIT_COUNT: dev_word[7:0] = nlu; // R18
      `SDS_OFS_WELL_KNOWN: dev_word[7:0] = `SDS_RST_WELL_KNOWN; // R18
      `SDS_OFS_BOOT_ALLOW: dev_word[7:0] = c.boot_allow; // R26
      `SDS_OFS_DESCR_ALLOW: dev_word[7:0] = c.descr_allow;
      `SDS_OFS_INIT_POWER: dev_word[7:0] = c.init_power;
      `SDS_OFS_PRIORITY: dev_word[7:0] = c.priority_unit;
      `SDS_OFS_REMOVAL: dev_word[7:0] = c.removal;
      `SDS_OFS_SECURE_UNIT: dev_word[7:0] = `SDS_RST_SECURE_UNIT;
      `SDS_OFS_BG_LATENCY: dev_word[7:0] = `SDS_RST_BG_LATENCY; // R06
      `SDS_OFS_ICC_LEVEL: dev_word[7:0] = c.icc_level;
      `SDS_OFS_SPEC_VER: dev_word[15:0] = `SDS_RST_SPEC_VER; // R07
      `SDS_OFS_BUILD_DATE: dev_word[15:0] = BUILD_DATE;
      `SDS_OFS_MAKER_STR: dev_word[7:0] = 8'h00;
      `SDS_OFS_PRODUCT_STR: dev_word[7:0] = 8'h01;
      `SDS_OFS_SERIAL_STR: dev_word[7:0] = 8'h02;
      `SDS_OFS_OEM_STR: dev_word[7:0] = 8'h03;
      `SDS_OFS_MAKER_CODE: dev_word[15:0] = MAKER_CODE; // R08
      `SDS_OFS_UCFG_BASE: dev_word[7:0] = `SDS_RST_UCFG;
      `SDS_OFS_UCFG_LEN: dev_word[7:0] = `SDS_RST_UCFG;
      `SDS_OFS_XFER_LIMIT: dev_word[7:0] = `SDS_RST_XFER_LIMIT; // R09
      `SDS_OFS_CLK_UPDATE: dev_word[15:0] = c.clock_update; // R10
      `SDS_OFS_FEATURES: dev_word[7:0] = `SDS_RST_FEATURES; // R13
      `SDS_OFS_FW_TIMEOUT: dev_word[7:0] = `SDS_RST_FW_TIMEOUT; // R14
      `SDS_OFS_QUEUE_DEPTH: dev_word[7:0] = `SDS_RST_QUEUE_DEPTH; // R15
      `SDS_OFS_DEV_REV: dev_word[15:0] = DEVICE_REV;
      `SDS_OFS_PROT_AREAS: dev_word[7:0] = `SDS_RST_PROT_AREAS;
      `SDS_OFS_PSA_MAX: dev_word = PSA_MAX_DATA;
      `SDS_OFS_PSA_TIMEOUT: dev_word[7:0] = `SDS_RST_PSA_TIMEOUT; // R16
      `SDS_OFS_REV_STR: dev_word[7:0] = 8'h04;
      default: dev_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [31:0] unit_word(input logic [5:0] idx,
                                            input logic [1:0] u,
                                            input sds_unit_t d);
    unit_word = 32'h0000_0000;
    case (idx)
      6'h00: unit_word[7:0] = `SDS_UNIT_LEN_VAL; // R24
      6'h01: unit_word[7:0] = `SDS_UNIT_ID_VAL; // R24
      6'h02: unit_word[1:0] = u;
      6'h03: unit_word[7:0] = d.enable_code; // R26
      6'h04: unit_word[7:0] = d.boot_id;
      6'h05: unit_word[7:0] = d.protect_code;
      6'h07: unit_word[7:0] = `SDS_RST_PSA_SENS;
      6'h0a: unit_word[7:0] = d.block_exp;
      default: unit_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [31:0] cfg_word(input logic [6:0] idx,
                                           input logic [7:0] cont,
                                           input sds_devcfg_t c,
                                           input sds_unit_t [`SDS_UNITS-1:0] su);
    logic [6:0] rel;
    rel = idx - `SDS_CFG_UNIT0;
    cfg_word = 32'h0000_0000;
    if (idx >= `SDS_CFG_UNIT0)
    begin
      case (rel[3:0])
        4'h0: cfg_word[7:0] = su[rel[5:4]].enable_code;
        4'h1: cfg_word[7:0] = su[rel[5:4]].boot_id;
        4'h2: cfg_word[7:0] = su[rel[5:4]].protect_code;
        4'h3: cfg_word[7:0] = su[rel[5:4]].block_exp;
        default: cfg_word = 32'h0000_0000;
      endcase
    end
    else
    begin
      case (idx)
        7'h00: cfg_word[7:0] = `SDS_CFG_LEN_VAL; // R24
        7'h01: cfg_word[7:0] = `SDS_CFG_ID_VAL; // R24
        `SDS_CFG_CONT: cfg_word[7:0] = cont;
        `SDS_CFG_BOOT: cfg_word[7:0] = c.boot_allow;
        `SDS_CFG_DESCR: cfg_word[7:0] = c.descr_allow;
        `SDS_CFG_POWER: cfg_word[7:0] = c.init_power;
        `SDS_CFG_PRIORITY: cfg_word[7:0] = c.priority_unit;
        `SDS_CFG_REMOVAL: cfg_word[7:0] = c.removal;
        `SDS_CFG_ICC: cfg_word[7:0] = c.icc_level;
        `SDS_CFG_CLK: cfg_word[15:0] = c.clock_update;
        default: cfg_word = 32'h0000_0000;
      endcase
    end
  endfunction

  logic [1:0] rgn;
  logic [9:0] word;
  logic setup;
  logic access;
  logic [6:0] crel;
  logic [7:0] wb;
  logic [7:0] nlu;

  assign rgn = paddr[11:10];
  assign word = paddr[11:2] & 10'h0ff;
  assign setup = psel & ~penable;
  assign access = psel & penable & s_q.pready;
  assign wb = pwdata[7:0];
  assign crel = 7'(word) - `SDS_CFG_UNIT0;

  always_comb
  begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h0000_0000;
    nlu = 8'h00;
    // Answer decided in setup, so read data and error come from flops
    if (setup)
    begin
      s_d.pready = 1'b1;
      case (rgn)
        `SDS_RGN_DEV:
        begin
          if (word > 10'h03f)
            s_d.pslverr = 1'b1;
          else if (boot_partial_phase && s_q.live.descr_allow != 8'h01 &&
                   !pwrite) // R02
            s_d.pslverr = 1'b1;
          else if (!pwrite)
            s_d.prdata = dev_word(word[5:0], s_q.live, s_q.status.unit_count);
        end
        `SDS_RGN_CFG:
        begin
          if (word >= 10'(`SDS_CFG_END))
            s_d.pslverr = 1'b1;
          else if (pwrite && s_q.qstate == SDS_Q_IDLE) // R23
            s_d.pslverr = 1'b1;
          else if (pwrite && word[6:0] == `SDS_CFG_CONT && wb > 8'h01)
            s_d.pslverr = 1'b1;
          else if (!pwrite)
            s_d.prdata = cfg_word(word[6:0], s_q.cont_flag, s_q.staged,
                                  s_q.staged_units);
        end
        `SDS_RGN_UNIT:
        begin
          if (paddr[9:8] > 2'(`SDS_UNITS - 1) ||
              paddr[7:2] >= `SDS_UNIT_END || pwrite)
            s_d.pslverr = !pwrite || paddr[7:2] >= `SDS_UNIT_END;
          else
            s_d.prdata = unit_word(paddr[7:2], paddr[9:8],
                                   s_q.units[paddr[9:8]]);
        end
        `SDS_RGN_QRY:
        begin
          case (word)
            `SDS_QRY_REQ:
            begin
              s_d.prdata[7:0] = s_q.req_code;
              s_d.pslverr = pwrite && wb != `SDS_CODE_QREQ; // R23
            end
            `SDS_QRY_RESP: s_d.prdata[7:0] = s_q.resp_code;
            `SDS_QRY_STAT: s_d.prdata[1:0] = s_q.qstate;
            default: s_d.pslverr = 1'b1;
          endcase
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // Writes land only at the access edge; a refused configuration write changes nothing, a refused query request still updates req_code and resp_code
    if (access && pwrite && rgn == `SDS_RGN_QRY && word == `SDS_QRY_REQ)
    begin
      s_d.req_code = wb;
      if (wb == `SDS_CODE_QREQ)
      begin
        s_d.resp_code = `SDS_CODE_QRESP; // R23
        if (s_q.qstate == SDS_Q_IDLE)
          s_d.qstate = SDS_Q_OPEN;
      end
      else
        s_d.resp_code = 8'h00;
    end
    if (access && pwrite && !s_q.pslverr && rgn == `SDS_RGN_CFG)
    begin
      if (word[6:0] >= `SDS_CFG_UNIT0)
      begin
        case (crel[3:0])
          4'h0: s_d.staged_units[crel[5:4]].enable_code = wb;
          4'h1: s_d.staged_units[crel[5:4]].boot_id = wb;
          4'h2: s_d.staged_units[crel[5:4]].protect_code = wb;
          4'h3: s_d.staged_units[crel[5:4]].block_exp = wb;
          default: s_d.cont_flag = s_q.cont_flag;
        endcase
      end
      else
      begin
        case (word[6:0])
          `SDS_CFG_BOOT: s_d.staged.boot_allow = wb;
          `SDS_CFG_DESCR: s_d.staged.descr_allow = wb;
          `SDS_CFG_POWER: s_d.staged.init_power = wb;
          `SDS_CFG_PRIORITY: s_d.staged.priority_unit = wb;
          `SDS_CFG_REMOVAL: s_d.staged.removal = wb;
          `SDS_CFG_ICC: s_d.staged.icc_level = wb;
          `SDS_CFG_CLK: s_d.staged.clock_update = {6'h00, pwdata[9:0]};
          `SDS_CFG_CONT:
          begin
            s_d.cont_flag = wb;
            if (wb == 8'h01)
              s_d.qstate = SDS_Q_DEFER; // R17
            else
            begin
              // Reserved codes keep the previous setting
              s_d.qstate = SDS_Q_IDLE; // R17
              s_d.status.config_applied = 1'b1;
              s_d.live.boot_allow = pick(s_q.staged.boot_allow <= 8'h01,
                s_q.staged.boot_allow, s_q.live.boot_allow); // R01
              s_d.live.descr_allow = pick(s_q.staged.descr_allow <= 8'h01,
                s_q.staged.descr_allow, s_q.live.descr_allow); // R02
              s_d.live.init_power = pick(s_q.staged.init_power <= 8'h01,
                s_q.staged.init_power, s_q.live.init_power); // R03
              s_d.live.priority_unit = pick(
                s_q.staged.priority_unit < 8'(`SDS_UNITS) ||
                s_q.staged.priority_unit == `SDS_ALL_EQUAL,
                s_q.staged.priority_unit, s_q.live.priority_unit); // R04
              s_d.live.removal = pick(s_q.staged.removal <= 8'h03,
                s_q.staged.removal, s_q.live.removal); // R05
              s_d.live.icc_level = pick(s_q.staged.icc_level <= 8'h0f,
                s_q.staged.icc_level, s_q.live.icc_level);
              if (s_q.staged.clock_update[8:7] != 2'b11)
                s_d.live.clock_update = s_q.staged.clock_update; // R10
              for (int u = 0; u < `SDS_UNITS; u++)
              begin
                s_d.units[u].enable_code = pick(
                  s_q.staged_units[u].enable_code <= 8'h01,
                  s_q.staged_units[u].enable_code,
                  s_q.units[u].enable_code); // R19
                s_d.units[u].boot_id = pick(
                  s_q.staged_units[u].boot_id <= 8'h02,
                  s_q.staged_units[u].boot_id, s_q.units[u].boot_id); // R20
                s_d.units[u].protect_code = pick(
                  s_q.staged_units[u].protect_code <= 8'h02,
                  s_q.staged_units[u].protect_code,
                  s_q.units[u].protect_code); // R21
                s_d.units[u].block_exp = pick(
                  s_q.staged_units[u].block_exp >= `SDS_MIN_BLOCK_EXP,
                  s_q.staged_units[u].block_exp,
                  s_q.units[u].block_exp); // R22
              end
            end
          end
          default: s_d.cont_flag = s_q.cont_flag;
        endcase
      end
    end

    // Decoded view of the live settings
    s_d.status.boot_enabled = s_q.live.boot_allow == 8'h01; // R01
    s_d.status.descriptor_access = s_q.live.descr_allow == 8'h01; // R02
    if (init_done)
      s_d.status.power_active = s_q.live.init_power == 8'h01; // R03
    s_d.status.all_equal_priority =
      s_q.live.priority_unit == `SDS_ALL_EQUAL; // R04
    s_d.status.priority_unit = s_q.live.priority_unit;
    s_d.status.removal_mode = s_q.live.removal[1:0]; // R05
    s_d.status.time_origin_select = s_q.live.clock_update[9]; // R10
    s_d.status.time_unit = s_q.live.clock_update[8:6];
    s_d.status.clock_period_valid = s_q.live.clock_update[8:6] != 3'b000;
    s_d.status.time_period = s_q.live.clock_update[8:6] == 3'b000 ?
      6'h00 : s_q.live.clock_update[5:0]; // R11
    for (int u = 0; u < `SDS_UNITS; u++)
    begin
      s_d.status.units_enabled[u] = s_q.units[u].enable_code == 8'h00; // R19
      if (s_q.units[u].enable_code == 8'h00)
        nlu = nlu + 8'h01; // R18
      s_d.status.units_boot_a[u] = s_q.units[u].boot_id == 8'h01; // R20
      s_d.status.units_boot_b[u] = s_q.units[u].boot_id == 8'h02;
      s_d.status.units_write_blocked[u] =
        (s_q.units[u].protect_code == 8'h01 && power_on_protect_flag) ||
        (s_q.units[u].protect_code == 8'h02 &&
         permanent_protect_flag); // R21
    end
    s_d.status.unit_count = nlu; // R18

    // Background stop watchdog; a new request clears a late flag
    if (bg_stop_req)
    begin
      s_d.bg_busy = ~bg_idle;
      s_d.bg_cnt = 32'h0000_0000;
      // A watch running out on the request edge still reports late
      s_d.status.bg_stop_late = s_q.bg_busy && !bg_idle &&
        s_q.bg_cnt >= BG_STOP_CYCLES - 1; // R06
    end
    else if (s_q.bg_busy)
    begin
      if (bg_idle)
        s_d.bg_busy = 1'b0;
      else if (s_q.bg_cnt >= BG_STOP_CYCLES - 1)
      begin
        s_d.bg_busy = 1'b0;
        s_d.status.bg_stop_late = 1'b1; // R06
      end
      else
        s_d.bg_cnt = s_q.bg_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.live.init_power <= `SDS_RST_INIT_POWER;
      s_q.live.priority_unit <= `SDS_RST_PRIORITY;
      s_q.staged.init_power <= `SDS_RST_INIT_POWER;
      s_q.staged.priority_unit <= `SDS_RST_PRIORITY;
      for (int u = 0; u < `SDS_UNITS; u++)
      begin
        s_q.units[u].block_exp <= `SDS_RST_BLOCK_EXP;
        s_q.staged_units[u].block_exp <= `SDS_RST_BLOCK_EXP;
      end
      s_q.status.power_active <= 1'b1; // R03
      s_q.status.all_equal_priority <= 1'b1;
      s_q.status.priority_unit <= `SDS_RST_PRIORITY;
    end
    else
      s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign status = s_q.status;

endmodule
`default_nettype wire

// File: core/sds_map.svh
// Offsets, reset values, codes and timing constants of the descriptor store
`ifndef SDS_MAP_SVH
`define SDS_MAP_SVH
`define SDS_UNITS 4
`define SDS_ADDR_W 12
`define SDS_RGN_DEV 2'b00
`define SDS_RGN_CFG 2'b01
`define SDS_RGN_UNIT 2'b10
`define SDS_RGN_QRY 2'b11
`define SDS_QRY_REQ 10'h000
`define SDS_QRY_RESP 10'h001
`define SDS_QRY_STAT 10'h002
`define SDS_CODE_QREQ 8'h16
`define SDS_CODE_QRESP 8'h36
`define SDS_OFS_LENGTH 6'h00
`define SDS_OFS_TYPE 6'h01
`define SDS_OFS_PROTOCOL 6'h05
`define SDS_OFS_UNIT_COUNT 6'h06
`define SDS_OFS_WELL_KNOWN 6'h07
`define SDS_OFS_BOOT_ALLOW 6'h08
`define SDS_OFS_DESCR_ALLOW 6'h09
`define SDS_OFS_INIT_POWER 6'h0a
`define SDS_OFS_PRIORITY 6'h0b
`define SDS_OFS_REMOVAL 6'h0c
`define SDS_OFS_SECURE_UNIT 6'h0d
`define SDS_OFS_BG_LATENCY 6'h0e
`define SDS_OFS_ICC_LEVEL 6'h0f
`define SDS_OFS_SPEC_VER 6'h10
`define SDS_OFS_BUILD_DATE 6'h12
`define SDS_OFS_MAKER_STR 6'h14
`define SDS_OFS_PRODUCT_STR 6'h15
`define SDS_OFS_SERIAL_STR 6'h16
`define SDS_OFS_OEM_STR 6'h17
`define SDS_OFS_MAKER_CODE 6'h18
`define SDS_OFS_UCFG_BASE 6'h1a
`define SDS_OFS_UCFG_LEN 6'h1b
`define SDS_OFS_XFER_LIMIT 6'h1c
`define SDS_OFS_CLK_UPDATE 6'h1d
`define SDS_OFS_FEATURES 6'h1f
`define SDS_OFS_FW_TIMEOUT 6'h20
`define SDS_OFS_QUEUE_DEPTH 6'h21
`define SDS_OFS_DEV_REV 6'h22
`define SDS_OFS_PROT_AREAS 6'h24
`define SDS_OFS_PSA_MAX 6'h25
`define SDS_OFS_PSA_TIMEOUT 6'h29
`define SDS_OFS_REV_STR 6'h2a
`define SDS_CFG_CONT 7'h02
`define SDS_CFG_BOOT 7'h03
`define SDS_CFG_DESCR 7'h04
`define SDS_CFG_POWER 7'h05
`define SDS_CFG_PRIORITY 7'h06
`define SDS_CFG_REMOVAL 7'h07
`define SDS_CFG_ICC 7'h08
`define SDS_CFG_CLK 7'h09
`define SDS_CFG_UNIT0 7'h10
`define SDS_CFG_END 7'h50
`define SDS_UNIT_END 6'h23
`define SDS_DEV_LEN_VAL 8'h40
`define SDS_CFG_LEN_VAL 8'h90
`define SDS_UNIT_LEN_VAL 8'h23
`define SDS_DEV_ID_VAL 8'h00
`define SDS_CFG_ID_VAL 8'h01
`define SDS_UNIT_ID_VAL 8'h02
`define SDS_RST_WELL_KNOWN 8'h04
`define SDS_RST_INIT_POWER 8'h01
`define SDS_RST_PRIORITY 8'h7f
`define SDS_RST_SECURE_UNIT 8'h01
`define SDS_RST_BG_LATENCY 8'h05
`define SDS_RST_SPEC_VER 16'h0210
`define SDS_RST_XFER_LIMIT 8'h02
`define SDS_RST_FEATURES 8'h7f
`define SDS_RST_FW_TIMEOUT 8'h0a
`define SDS_RST_QUEUE_DEPTH 8'h20
`define SDS_RST_PROT_AREAS 8'h20
`define SDS_RST_PSA_TIMEOUT 8'h12
`define SDS_RST_UCFG 8'h10
`define SDS_RST_BLOCK_EXP 8'h0c
`define SDS_RST_PSA_SENS 8'h01
`define SDS_MIN_BLOCK_EXP 8'h0c
`define SDS_ALL_EQUAL 8'h7f
`define SDS_BG_UNIT_MS 10
`define SDS_CYC_PER_MS 125000
`endif

// File: core/sds_pkg.sv
// Types shared by the descriptor store
package sds_pkg;
  typedef enum logic [1:0] {
    SDS_Q_IDLE = 2'b00,
    SDS_Q_OPEN = 2'b01,
    SDS_Q_DEFER = 2'b10
  } sds_qstate_t;
  typedef struct packed {
    logic [7:0] enable_code;
    logic [7:0] boot_id;
    logic [7:0] protect_code;
    logic [7:0] block_exp;
  } sds_unit_t;
  typedef struct packed {
    logic [7:0] boot_allow;
    logic [7:0] descr_allow;
    logic [7:0] init_power;
    logic [7:0] priority_unit;
    logic [7:0] removal;
    logic [7:0] icc_level;
    logic [15:0] clock_update;
  } sds_devcfg_t;
  typedef struct packed {
    logic boot_enabled;
    logic descriptor_access;
    logic power_active;
    logic all_equal_priority;
    logic [7:0] priority_unit;
    logic [1:0] removal_mode;
    logic clock_period_valid;
    logic time_origin_select;
    logic [2:0] time_unit;
    logic [5:0] time_period;
    logic [3:0] units_enabled;
    logic [3:0] units_write_blocked;
    logic [3:0] units_boot_a;
    logic [3:0] units_boot_b;
    logic [7:0] unit_count;
    logic config_applied;
    logic bg_stop_late;
  } sds_status_t;
endpackage

// File: verif/sds_properties.sv
// Port-level properties of the descriptor store
`timescale 1ns/1ns
`default_nettype none
module sds_properties
  import sds_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bg_stop_req,
  input wire sds_status_t status
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_prio;
    status.all_equal_priority == (status.priority_unit == 8'h7f);
  endproperty
  a_prio: assert property (p_prio) else $error("priority flag wrong");
  property p_undef; status.time_unit == 3'h0 |->
    !status.clock_period_valid && status.time_period == 6'h00; endproperty
  a_undef: assert property (p_undef) else $error("period kept");
  property p_unit; status.time_unit < 3'h6; endproperty
  a_unit: assert property (p_unit) else $error("reserved time unit");
  property p_count;
    status.unit_count == 8'($countones(status.units_enabled));
  endproperty
  a_count: assert property (p_count) else $error("unit count wrong");
  property p_applied; status.config_applied |=> status.config_applied;
  endproperty
  a_applied: assert property (p_applied) else $error("apply lost");
  property p_rsvd; pready && !pwrite && !pslverr && paddr[11:10] == 2'h0
    && paddr[9:2] >= 8'h2b |-> prdata == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved not zero");
  property p_bg; bg_stop_req && status.bg_stop_late |=>
    !status.bg_stop_late; endproperty
  a_bg: assert property (p_bg) else $error("late flag kept");
endmodule
`default_nettype wire

// File: verif/sds_host.sv
// Host-side APB master issuing query traffic
`timescale 1ns/1ns
`default_nettype none
module sds_host (
  input wire logic mclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0
);
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic open_query(output logic e);
    logic [31:0] r;
    xfer(1'b1, 12'hc00, 32'h16, r, e);
  endtask
endmodule
`default_nettype wire

// File: verif/sds_store_bench.sv
// Self-checking bench for the descriptor store
`timescale 1ns/1ns
`default_nettype none
module sds_store_bench;
  import sds_pkg::*;
  // Arbitrary value, not a real maker code
  localparam logic [15:0] MAKER = 16'h3c3c;
  logic mclk = 1'b0, reset = 1'b1, init_done = 1'b0, bg_idle = 1'b1;
  logic boot_partial_phase = 1'b0, bg_stop_req = 1'b0;
  logic power_on_protect_flag = 1'b0, permanent_protect_flag = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, qe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  sds_status_t status;
  int failures = 0, tests_run = 0;
  always #4 mclk = ~mclk;
  sds_store #(.MAKER_CODE(MAKER), .BG_STOP_CYCLES(20)) sds_store_i (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .boot_partial_phase(boot_partial_phase), .init_done(init_done),
    .power_on_protect_flag(power_on_protect_flag), .bg_idle(bg_idle),
    .permanent_protect_flag(permanent_protect_flag), .status(status),
    .bg_stop_req(bg_stop_req), .pready(pready), .pslverr(pslverr));
  sds_host sds_host_i (.mclk(mclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      failures++;
  endtask
  task automatic io(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic e;
    sds_host_i.xfer(w, a, d, r, e);
    chk({63'h0, e}, {63'h0, ex});
    if (!w && !ex)
      chk({32'h0, r}, {32'h0, x});
  endtask
  task automatic wrap_up;
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset;
    logic [11:0] a [12] = '{12'h000, 12'h004, 12'h01c, 12'h028, 12'h02c,
      12'h038, 12'h040, 12'h070, 12'h07c, 12'h080, 12'h084, 12'h0a4};
    logic [31:0] x [12] = '{32'h40, 32'h00, 32'h04, 32'h01, 32'h7f,
      32'h05, 32'h0210, 32'h02, 32'h7f, 32'h0a, 32'h20, 32'h12};
    for (int i = 0; i < 12; i++)
      io(1'b0, a[i], 32'h0, x[i], 1'b0);
  endtask
  task automatic t_refuse;
    io(1'b1, 12'h060, 32'hffff, 32'h0, 1'b0);
    io(1'b0, 12'h060, 32'h0, {16'h0, MAKER}, 1'b0);
    io(1'b0, 12'h0b0, 32'h0, 32'h0, 1'b0);
    io(1'b1, 12'h40c, 32'h1, 32'h0, 1'b1);
    io(1'b0, 12'hffc, 32'h0, 32'h0, 1'b1);
    boot_partial_phase <= 1'b1;
    io(1'b0, 12'h000, 32'h0, 32'h0, 1'b1);
    boot_partial_phase <= 1'b0;
  endtask
  task automatic t_config;
    logic [11:0] a [10] = '{12'h40c, 12'h410, 12'h414, 12'h418, 12'h41c,
      12'h424, 12'h480, 12'h444, 12'h4c8, 12'h504};
    logic [31:0] d [10] = '{32'h1, 32'h1, 32'h0, 32'h2, 32'h3, 32'h285,
      32'h1, 32'h1, 32'h1, 32'h2};
    sds_status_t s = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h02, 2'h3, 1'b1, 1'b1,
      3'h2, 6'h05, 4'hd, 4'h0, 4'h1, 4'h8, 8'h03, 1'b1, 1'b0};
    sds_host_i.open_query(qe);
    chk({63'h0, qe}, 64'h0);
    io(1'b0, 12'hc04, 32'h0, 32'h36, 1'b0);
    for (int i = 0; i < 10; i++)
      io(1'b1, a[i], d[i], 32'h0, 1'b0);
    io(1'b1, 12'h408, 32'h1, 32'h0, 1'b0);
    io(1'b0, 12'hc08, 32'h0, 32'h2, 1'b0);
    chk({63'h0, status.config_applied}, 64'h0);
    io(1'b1, 12'h408, 32'h2, 32'h0, 1'b1);
    io(1'b1, 12'h408, 32'h0, 32'h0, 1'b0);
    repeat (2) @(negedge mclk);
    chk(64'(status), 64'(s));
    io(1'b0, 12'h018, 32'h0, 32'h3, 1'b0);
    io(1'b0, 12'h90c, 32'h0, 32'h1, 1'b0);
    io(1'b0, 12'h828, 32'h0, 32'h0c, 1'b0);
  endtask
  task automatic t_pins;
    @(posedge mclk);
    init_done <= 1'b1;
    power_on_protect_flag <= 1'b1;
    bg_idle <= 1'b0;
    bg_stop_req <= 1'b1;
    @(posedge mclk);
    init_done <= 1'b0;
    bg_stop_req <= 1'b0;
    repeat (2) @(negedge mclk);
    chk({63'h0, status.power_active}, 64'h0);
    chk({60'h0, status.units_write_blocked}, 64'h4);
    chk({63'h0, status.bg_stop_late}, 64'h0);
    repeat (30) @(negedge mclk);
    chk({63'h0, status.bg_stop_late}, 64'h1);
    @(posedge mclk);
    bg_idle <= 1'b1;
    bg_stop_req <= 1'b1;
    @(posedge mclk);
    bg_stop_req <= 1'b0;
    @(negedge mclk);
    chk({63'h0, status.bg_stop_late}, 64'h0);
  endtask
  initial
  begin
    repeat (3000) @(posedge mclk);
    failures++;
    wrap_up();
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_refuse();
    t_config();
    t_pins();
    wrap_up();
  end
endmodule
bind sds_store sds_properties sds_properties_i (.mclk(mclk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bg_stop_req(bg_stop_req), .status(status));
`default_nettype wire
